// >>> logic/dtpg_pkg.sv
// Package for the detector timing pulse generator: constants and carrier types
package dtpg_pkg;

	// ======================================================================
	// Clock and timing
	// ======================================================================
	localparam int CLK_PERIOD_NS = 50;
	// Least quiet time after the hold-off window before a deferred event
	localparam int HOLD_QUIET_NS = 1000;
	localparam int HOLD_QUIET_CYC = (HOLD_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Longest delay after the hold-off window for a deferred event
	localparam int HOLD_LATE_NS = 10000;
	localparam int HOLD_LATE_CYC = HOLD_LATE_NS / CLK_PERIOD_NS;
	// Base tick of the time base is half a millisecond
	localparam int HALF_MS_NS = 500000;
	localparam int HALF_MS_CYC = HALF_MS_NS / CLK_PERIOD_NS;

	// ======================================================================
	// Widths and time-base ratios
	// ======================================================================
	localparam int QUIET_W = 8;
	localparam logic [QUIET_W-1:0] QUIET_DONE = QUIET_W'(HOLD_QUIET_CYC);
	localparam int HMS_W = 8;
	localparam logic [HMS_W-1:0] HMS_PER_MS = 8'h02;
	localparam logic [HMS_W-1:0] HMS_PER_100MS = 8'hC8;
	localparam int CLR_PER_W = 5;
	localparam int CAL_PER_W = 12;
	localparam int MRK_PER_W = 8;
	localparam int DLY_W = 3;
	localparam int DLY_TAPS = 7;

	// ======================================================================
	// Values after reset
	// ======================================================================
	localparam logic [CLR_PER_W-1:0] CLR_PER_RST = 5'h01;
	localparam logic [CAL_PER_W-1:0] CAL_PER_RST = 12'h001;
	localparam logic [MRK_PER_W-1:0] MRK_PER_RST = 8'h01;

	// ======================================================================
	// Carrier types
	// ======================================================================
	// Periods: clear in 100 ms units, calib in 1 ms units, marker in 1 ms units
	typedef struct packed {
		logic [CLR_PER_W-1:0] clear_period;
		logic [CAL_PER_W-1:0] calib_period;
		logic [MRK_PER_W-1:0] marker_period;
	} dtpg_period_t;

	// Per-fan-out delays in whole clock cycles
	typedef struct packed {
		logic [DLY_W-1:0] beam;
		logic [DLY_W-1:0] clear;
		logic [DLY_W-1:0] calib;
	} dtpg_fan_dly_t;

endpackage : dtpg_pkg

// >>> logic/dtpg_gen.sv
// Detector timing pulse generator with per-fan-out delays and hold-off
`timescale 1ns/1ps

// Contract
// R1 - Beam window output changes on a clock edge, well before receiver sampling.
// R2 - Beam window shifts together with its fan-out clock phase.
// R3 - Per-fan-out beam window delay of 0 to 7 cycles, 3 bits.
// R4 - Counter clear is periodic, 0.1 s to 3 s in 0.1 s steps.
// R5 - Counter clear lasts exactly one clock cycle.
// R6 - Counter clear changes on a clock edge, well before receiver sampling.
// R7 - Counter clear shifts together with its fan-out clock phase.
// R8 - Per-fan-out counter clear delay of 0 to 7 cycles.
// R9 - No counter clear during beam window; deferred until 1 us after.
// R10 - Calib reference period 1 ms to 4 s in 1 ms steps, 12 bits.
// R11 - Calib pulse is periodic and lasts exactly one cycle.
// R12 - Calib pulse changes on a clock edge, well before receiver sampling.
// R13 - Calib pulse shifts together with its fan-out clock phase.
// R14 - Per-fan-out calib pulse delay of 0 to 7 cycles.
// R15 - No calib pulse during beam window; deferred until 1 us after.
// R16 - Time block marker is a square wave with equal halves.
// R17 - Marker period 1 ms to 255 ms in 1 ms steps, 8 bits.
// R18 - Marker changes on a clock edge, well before receiver sampling.
// R19 - Marker shifts together with its fan-out clock phase.
// R20 - No marker change during data transfer; deferred until 1 us after.
// R21 - Deferred events issue 1 us to 10 us after combined hold-off ends.
// R22 - Avoid calib pulse and counter clear in the same cycle.
// R23 - Readout side supplies a transfer-complete indication.
// R24 - Settings are held and take effect at the next period boundary.
module dtpg_gen import dtpg_pkg::*; #(
	parameter int FANOUTS = 4,
	parameter int HMS_CYCLES = HALF_MS_CYC
) (
	input wire logic clk, // 20 MHz clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic beam_window_in, // Global beam window reference
	input wire logic xfer_done, // Pulse: spill data transfer complete
	input wire dtpg_period_t periods, // Period settings
	input wire dtpg_fan_dly_t [FANOUTS-1:0] fan_dly, // Per-fan-out delays
	output logic [FANOUTS-1:0] beam_window, // Delayed beam window per fan-out
	output logic [FANOUTS-1:0] counter_clear_pulse, // Counter clear per fan-out
	output logic [FANOUTS-1:0] timing_calib_pulse, // Calib pulse per fan-out
	output logic [FANOUTS-1:0] time_block_marker, // Marker per fan-out
	output logic hold_off_active // Combined hold-off window in force
);

	localparam int PS_W = $clog2(HMS_CYCLES + 1);
	localparam logic [PS_W-1:0] PS_LAST = PS_W'(HMS_CYCLES - 1);

	// Tap select shared by all delay lines; tap 0 is the undelayed global
	function automatic logic tap_sel(input logic glb, input logic [DLY_TAPS-1:0] line,
			input logic [DLY_W-1:0] dly);
		logic res;
		res = glb;
		if (dly != '0) begin
			res = line[dly - 3'h1];
		end
		return res;
	endfunction : tap_sel

	// ======================================================================
	// Time base: half-ms, 1 ms and 100 ms ticks
	// ======================================================================
	logic [PS_W-1:0] ps_cnt_r;
	logic tick_hms;
	logic [HMS_W-1:0] ms_cnt_r;
	logic [HMS_W-1:0] cms_cnt_r;
	logic tick_ms;
	logic tick_100ms;

	assign tick_hms = (ps_cnt_r == PS_LAST);
	assign tick_ms = tick_hms && (ms_cnt_r == HMS_PER_MS - 8'h01);
	assign tick_100ms = tick_hms && (cms_cnt_r == HMS_PER_100MS - 8'h01);

	always_ff @(posedge clk) begin
		if (rst || tick_hms) begin
			ps_cnt_r <= '0;
		end else begin
			ps_cnt_r <= ps_cnt_r + PS_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ms_cnt_r <= '0;
			cms_cnt_r <= '0;
		end else if (tick_hms) begin
			ms_cnt_r <= tick_ms ? '0 : ms_cnt_r + 8'h01;
			cms_cnt_r <= tick_100ms ? '0 : cms_cnt_r + 8'h01;
		end
	end

	// ======================================================================
	// Hold-off window: beam start to transfer complete
	// ======================================================================
	logic beam_prev_r;
	logic xfer_pend_r;
	logic hold;
	logic [QUIET_W-1:0] quiet_r;
	logic release_ok;

	assign hold = beam_window_in || xfer_pend_r;
	assign release_ok = !hold && (quiet_r == QUIET_DONE);

	always_ff @(posedge clk) begin
		if (rst) begin
			beam_prev_r <= 1'b0;
			xfer_pend_r <= 1'b0;
		end else begin
			beam_prev_r <= beam_window_in;
			// A new spill start wins over a transfer-complete in the same cycle [R23]
			if (beam_window_in && !beam_prev_r) begin
				xfer_pend_r <= 1'b1;
			end else if (xfer_done) begin
				xfer_pend_r <= 1'b0;
			end
		end
	end

	// Quiet-time counter after the window ends [R9] [R15] [R20] [R21]
	always_ff @(posedge clk) begin
		if (rst || hold) begin
			quiet_r <= '0;
		end else if (quiet_r != QUIET_DONE) begin
			quiet_r <= quiet_r + 8'h01;
		end
	end

	// ======================================================================
	// Period generators with settings latched at each boundary
	// ======================================================================
	logic [CLR_PER_W-1:0] clr_per_r;
	logic [CLR_PER_W-1:0] clr_cnt_r;
	logic [CAL_PER_W-1:0] cal_per_r;
	logic [CAL_PER_W-1:0] cal_cnt_r;
	logic [MRK_PER_W-1:0] mrk_per_r;
	logic [MRK_PER_W-1:0] mrk_cnt_r;
	logic clr_due;
	logic cal_due;
	logic mrk_due;

	assign clr_due = tick_100ms && (clr_cnt_r >= clr_per_r - 5'h01);
	assign cal_due = tick_ms && (cal_cnt_r >= cal_per_r - 12'h001);
	assign mrk_due = tick_hms && (mrk_cnt_r >= mrk_per_r - 8'h01);

	always_ff @(posedge clk) begin
		if (rst) begin
			clr_per_r <= CLR_PER_RST;
			clr_cnt_r <= '0;
		end else if (clr_due) begin // [R4] [R24]
			clr_cnt_r <= '0;
			clr_per_r <= (periods.clear_period == '0) ? CLR_PER_RST : periods.clear_period;
		end else if (tick_100ms) begin
			clr_cnt_r <= clr_cnt_r + 5'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cal_per_r <= CAL_PER_RST;
			cal_cnt_r <= '0;
		end else if (cal_due) begin // [R10] [R24]
			cal_cnt_r <= '0;
			cal_per_r <= (periods.calib_period == '0) ? CAL_PER_RST : periods.calib_period;
		end else if (tick_ms) begin
			cal_cnt_r <= cal_cnt_r + 12'h001;
		end
	end

	// Half period counted in half-ms ticks gives equal halves [R16] [R17]
	always_ff @(posedge clk) begin
		if (rst) begin
			mrk_per_r <= MRK_PER_RST;
			mrk_cnt_r <= '0;
		end else if (mrk_due) begin // [R24]
			mrk_cnt_r <= '0;
			mrk_per_r <= (periods.marker_period == '0) ? MRK_PER_RST : periods.marker_period;
		end else if (tick_hms) begin
			mrk_cnt_r <= mrk_cnt_r + 8'h01;
		end
	end

	// ======================================================================
	// Pending events and global signals
	// ======================================================================
	logic clr_pend_r;
	logic cal_pend_r;
	logic mrk_pend_r;
	logic clr_fire;
	logic cal_fire;
	logic mrk_fire;
	logic clear_glb_r;
	logic calib_glb_r;
	logic marker_glb_r;
	logic beam_glb_r;

	// A pulse still high blocks a refire, so a boundary on the firing cycle cannot stretch it
	assign clr_fire = clr_pend_r && release_ok && !clear_glb_r; // [R5] [R9] [R21]
	assign cal_fire = cal_pend_r && release_ok && !clr_fire && !calib_glb_r; // [R11] [R15] [R22]
	assign mrk_fire = mrk_pend_r && release_ok; // [R20]

	// A new period boundary wins over the firing that clears the flag
	always_ff @(posedge clk) begin
		if (rst) begin
			clr_pend_r <= 1'b0;
			cal_pend_r <= 1'b0;
			mrk_pend_r <= 1'b0;
		end else begin
			clr_pend_r <= clr_due || (clr_pend_r && !clr_fire);
			cal_pend_r <= cal_due || (cal_pend_r && !cal_fire);
			mrk_pend_r <= mrk_due || (mrk_pend_r && !mrk_fire);
		end
	end

	// One-cycle pulses and the marker toggle, all from flops [R5] [R11]
	always_ff @(posedge clk) begin
		if (rst) begin
			clear_glb_r <= 1'b0;
			calib_glb_r <= 1'b0;
			marker_glb_r <= 1'b0;
			beam_glb_r <= 1'b0;
		end else begin
			clear_glb_r <= clr_fire;
			calib_glb_r <= cal_fire;
			beam_glb_r <= beam_window_in; // [R1]
			if (mrk_fire) begin
				marker_glb_r <= !marker_glb_r;
			end
		end
	end

	// ======================================================================
	// Shared delay lines with per-fan-out taps and output flop bank
	// ======================================================================
	logic [DLY_TAPS-1:0] beam_line_r;
	logic [DLY_TAPS-1:0] clear_line_r;
	logic [DLY_TAPS-1:0] calib_line_r;
	logic [FANOUTS-1:0] beam_out_r;
	logic [FANOUTS-1:0] clear_out_r;
	logic [FANOUTS-1:0] calib_out_r;
	logic [FANOUTS-1:0] marker_out_r;
	logic hold_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			beam_line_r <= '0;
			clear_line_r <= '0;
			calib_line_r <= '0;
		end else begin
			beam_line_r <= {beam_line_r[DLY_TAPS-2:0], beam_glb_r};
			clear_line_r <= {clear_line_r[DLY_TAPS-2:0], clear_glb_r};
			calib_line_r <= {calib_line_r[DLY_TAPS-2:0], calib_glb_r};
		end
	end

	// All four signals of a fan-out leave from one flop bank on the same edge,
	// so a downstream phase shift of that fan-out's clock moves them together
	genvar gi;
	generate
		for (gi = 0; gi < FANOUTS; gi++) begin : g_fan
			always_ff @(posedge clk) begin
				if (rst) begin
					beam_out_r[gi] <= 1'b0;
					clear_out_r[gi] <= 1'b0;
					calib_out_r[gi] <= 1'b0;
					marker_out_r[gi] <= 1'b0;
				end else begin
					beam_out_r[gi] <= tap_sel(beam_glb_r, beam_line_r, fan_dly[gi].beam); // [R2] [R3]
					clear_out_r[gi] <= tap_sel(clear_glb_r, clear_line_r, fan_dly[gi].clear); // [R7] [R8]
					calib_out_r[gi] <= tap_sel(calib_glb_r, calib_line_r, fan_dly[gi].calib); // [R13] [R14]
					marker_out_r[gi] <= marker_glb_r; // [R18] [R19]
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (rst) begin
			hold_r <= 1'b0;
		end else begin
			hold_r <= hold;
		end
	end

	// Outputs change only at clk edges, leaving a full period of setup [R6] [R12]
	assign beam_window = beam_out_r;
	assign counter_clear_pulse = clear_out_r;
	assign timing_calib_pulse = calib_out_r;
	assign time_block_marker = marker_out_r;
	assign hold_off_active = hold_r;

	// ======================================================================
	// Assertions
	// ======================================================================
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_clr_one_cycle;
		clear_glb_r |=> !clear_glb_r;
	endproperty
	a_clr_one_cycle: assert property (p_clr_one_cycle) else $error("clear pulse too long"); // [R5]

	property p_cal_one_cycle;
		calib_glb_r |=> !calib_glb_r;
	endproperty
	a_cal_one_cycle: assert property (p_cal_one_cycle) else $error("calib pulse too long"); // [R11]

	property p_clr_not_in_hold;
		beam_window_in |=> !clear_glb_r && !calib_glb_r;
	endproperty
	a_clr_not_in_hold: assert property (p_clr_not_in_hold) else $error("pulse during beam"); // [R9] [R15]

	property p_clr_quiet;
		clear_glb_r |-> $past(quiet_r) == QUIET_DONE && !$past(hold);
	endproperty
	a_clr_quiet: assert property (p_clr_quiet) else $error("clear before quiet time"); // [R9]

	property p_clr_late;
		clr_pend_r && !hold && quiet_r == QUIET_DONE && !clear_glb_r |=> clear_glb_r;
	endproperty
	a_clr_late: assert property (p_clr_late) else $error("deferred clear not issued"); // [R21]

	property p_cal_late;
		cal_pend_r && !hold && quiet_r == QUIET_DONE |-> ##[1:2] calib_glb_r;
	endproperty
	a_cal_late: assert property (p_cal_late) else $error("deferred calib not issued"); // [R21]

	property p_no_overlap;
		!(clear_glb_r && calib_glb_r);
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("clear and calib together"); // [R22]

	property p_marker_hold;
		hold |=> $stable(marker_glb_r);
	endproperty
	a_marker_hold: assert property (p_marker_hold) else $error("marker moved in hold"); // [R20]

	property p_beam_dly2;
		$past(fan_dly[FANOUTS-1].beam) == 3'h2 |-> beam_out_r[FANOUTS-1] == $past(beam_glb_r, 3);
	endproperty
	a_beam_dly2: assert property (p_beam_dly2) else $error("beam delay wrong"); // [R3]

	property p_beam_follow;
		beam_glb_r == $past(beam_window_in);
	endproperty
	a_beam_follow: assert property (p_beam_follow) else $error("beam not registered"); // [R1]

	c_clr_after_hold: cover property ($fell(hold) ##[1:40] clear_glb_r);
	c_cal_fire: cover property (calib_glb_r);
	c_marker_rise: cover property ($rose(marker_glb_r));
	c_xfer_end: cover property ($fell(xfer_pend_r));

endmodule : dtpg_gen

// >>> sim/dtpg_fe_model.sv
// Readout side model: answers each spill with a transfer-complete pulse
`timescale 1ns/1ps
module dtpg_fe_model #(
	parameter int FANOUTS = 4
) (
	input wire logic clk, // 20 MHz clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic [FANOUTS-1:0] beam_window, // Beam window per fan-out
	input wire logic [7:0] xfer_lat, // Cycles from beam end to done, less 2
	output logic xfer_done // Transfer complete pulse
);
	logic bw_r = 1'b0;
	logic busy_r = 1'b0;
	logic done_r = 1'b0;
	logic [7:0] cnt_r = 8'h00;
	assign xfer_done = done_r;
	// ======================================================================
	// Transfer runs xfer_lat + 1 cycles from the cycle after the beam window falls; done comes xfer_lat + 2 cycles after the fall
	// ======================================================================
	always_ff @(posedge clk) begin
		bw_r <= beam_window[0];
		done_r <= 1'b0;
		if (rst) begin
			busy_r <= 1'b0;
		end else if (bw_r && !beam_window[0]) begin
			busy_r <= 1'b1;
			cnt_r <= xfer_lat;
		end else if (busy_r) begin
			if (cnt_r == 8'h00) begin
				busy_r <= 1'b0;
				done_r <= 1'b1;
			end else begin
				cnt_r <= cnt_r - 8'h01;
			end
		end
	end
endmodule : dtpg_fe_model

// >>> sim/testbench.sv
// Self-checking bench for the detector timing pulse generator
`timescale 1ns/1ps
module testbench import dtpg_pkg::*;;
	localparam int FANOUTS = 4;
	logic clk;
	logic rst;
	logic beam_window_in;
	logic xfer_done;
	logic [7:0] xfer_lat;
	dtpg_period_t periods;
	dtpg_fan_dly_t [FANOUTS-1:0] fan_dly;
	logic [FANOUTS-1:0] beam_window, counter_clear_pulse, timing_calib_pulse, time_block_marker;
	logic [FANOUTS-1:0] bw_p, clr_p, cal_p, mk_p;
	logic hold_off_active;
	logic [31:0] seed;
	int miscompares = 0;
	int n_tests = 0;
	int cyc = 0;
	int t_ev[3] = '{-1, -1, -1};
	// Calib and marker start from a latched period of 1 and the post-reset quiet time
	int skip[3] = '{0, 2, 2};
	int expv[3];
	bit chk[3] = '{0, 0, 0};
	int t_end, t_bw0;
	bit in_hold = 0;
	bit bw0_p = 0;
	int exp_q[FANOUTS][$];

	dtpg_gen #(.FANOUTS(FANOUTS), .HMS_CYCLES(4)) DUT (.clk(clk), .rst(rst),
		.beam_window_in(beam_window_in), .xfer_done(xfer_done), .periods(periods),
		.fan_dly(fan_dly), .beam_window(beam_window), .counter_clear_pulse(counter_clear_pulse),
		.timing_calib_pulse(timing_calib_pulse), .time_block_marker(time_block_marker),
		.hold_off_active(hold_off_active));
	dtpg_fe_model #(.FANOUTS(FANOUTS)) fe (.clk(clk), .rst(rst), .beam_window(beam_window),
		.xfer_lat(xfer_lat), .xfer_done(xfer_done));

	// ======================================================================
	// Shared tasks
	// ======================================================================
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	task automatic stop_test();
		if (miscompares == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test

	// Event on fan-out 0 of stream k: 0 clear, 1 calib, 2 marker
	task automatic fan0_event(input int k);
		if (in_hold) check("held_event", 1'b1, 1'b0);
		if (chk[k]) check("defer_delay", (cyc - t_end >= 20) && (cyc - t_end <= 202), 1'b1);
		else if (t_ev[k] >= 0 && skip[k] == 0) check("period", cyc - t_ev[k], expv[k]);
		if (!chk[k] && skip[k] > 0) skip[k]--;
		chk[k] = 0;
		t_ev[k] = cyc;
	endtask : fan0_event

	task automatic pulses(input int k, input logic [FANOUTS-1:0] v, input logic [FANOUTS-1:0] p);
		for (int i = 0; i < FANOUTS; i++) begin
			if (v[i]) begin
				check("pulse_width", p[i], 1'b0);
				if (i == 0) fan0_event(k);
				else check("fan_delay", cyc - t_ev[k], k == 0 ? fan_dly[i].clear : fan_dly[i].calib);
			end
		end
	endtask : pulses

	task automatic spill(input logic [7:0] lat, input int len);
		@(posedge clk);
		xfer_lat <= lat;
		beam_window_in <= 1'b1;
		for (int i = 0; i < FANOUTS; i++) exp_q[i].push_back(fan_dly[i].beam);
		repeat (len) @(posedge clk);
		#1 check("hold_off", hold_off_active, 1'b1);
		@(posedge clk);
		beam_window_in <= 1'b0;
		repeat (300 + lat) @(posedge clk);
		#1 check("deferred_missing", chk[1] | chk[2], 1'b0);
		check("hold_off_end", hold_off_active, 1'b0);
	endtask : spill

	// ======================================================================
	// Clock, watchdog, output monitor
	// ======================================================================
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) cyc <= cyc + 1;

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		stop_test();
	end

	initial begin
		forever begin
			@(posedge clk);
			#1;
			if (!rst) begin
				if (beam_window[0] && bw0_p) in_hold = 1;
				if (xfer_done && in_hold) begin
					in_hold = 0;
					t_end = cyc;
					chk[1] = 1;
					chk[2] = 1;
					skip = '{1, 1, 2};
				end
				for (int i = 0; i < FANOUTS; i++) begin
					if (beam_window[i] && !bw_p[i]) begin
						if (i == 0) t_bw0 = cyc;
						if (exp_q[i].size() > 0) check("beam_delay", cyc - t_bw0, exp_q[i].pop_front());
					end
				end
				pulses(0, counter_clear_pulse, clr_p);
				if (counter_clear_pulse[0]) skip[1] = 2;
				pulses(1, timing_calib_pulse, cal_p);
				check("clear_calib_same", counter_clear_pulse[0] & timing_calib_pulse[0], 1'b0);
				if (time_block_marker[0] != mk_p[0]) begin
					fan0_event(2);
					check("marker_fans", time_block_marker, {FANOUTS{time_block_marker[0]}});
				end
			end
			bw0_p = beam_window[0];
			bw_p = beam_window;
			clr_p = counter_clear_pulse;
			cal_p = timing_calib_pulse;
			mk_p = time_block_marker;
		end
	end

	// ======================================================================
	// Main sequence
	// ======================================================================
	initial begin
		rst = 1'b1;
		beam_window_in = 1'b0;
		xfer_lat = 8'h00;
		periods = '{clear_period: 5'h01, calib_period: 12'h003, marker_period: 8'h03};
		expv = '{800, 24, 12};
		seed = 32'hD090C9F0;
		fan_dly[0] = '0;
		for (int i = 1; i < FANOUTS; i++) begin
			seed = lfsr(seed);
			fan_dly[i] = seed[8:0];
		end
		fan_dly[FANOUTS-1].beam = 3'h2;
		repeat (15) @(posedge clk);
		#1 check("reset_out", {beam_window, counter_clear_pulse, timing_calib_pulse,
			time_block_marker, hold_off_active}, '0);
		@(posedge clk);
		rst <= 1'b0;
		repeat (1800) @(posedge clk);
		seed = lfsr(seed);
		spill(8'h1E, 40 + int'(seed[4:0]));
		spill(8'h00, 60);
		@(posedge clk);
		periods.calib_period <= 12'h005;
		expv[1] = 40;
		skip[1] = 2;
		repeat (300) @(posedge clk);
		check("calib_seen", t_ev[1] > cyc - 60, 1'b1);
		stop_test();
	end
endmodule : testbench
